// file: rtl/dcsu_top.v
// Purpose: two full duplex serial channels, each with its own transmit and receive rate generators
// Assumes: host side signals are synchronous to clock_in
// Notes:   channel index 0 is channel a, 1 is channel b
// Overview of operation
// - generator gives sixteen-times ticks for nineteen fixed rates
// - each receiver and transmitter picks its own rate
// - per channel clock select may route the external clock pin
// - external clock is a bit clock or a sixteen-times clock
// - receiver samples on the rising edge of its clock
// - transmitter changes its output on the falling edge
// - serial output sits at mark when idle, looped, or disabled once the current character ends
// - transmitter sends least significant bit first
// - receiver assembles least significant bit first
// - transmitter frames with start, data, parity and stop bits
// - five to eight data bits plus optional parity
// - parity odd, even, none or forced, both directions
// - stop length nine-sixteenths to two bits in sixteenths; one or two whole bits on a bit clock
// - receiver checks stop, parity and break per character, and rechecks start except on a bit clock
// - parity, framing and overrun errors are flagged
// - breaks detected at the stop bit of an all-zero character; start and end reported
// - status view shows active conditions; mask gates interrupt
// - after stop bits with nothing waiting, hold mark and flag empty
`timescale 1ns/100ps
`default_nettype none
`include "dcsu_map.vh"
module dcsu_top #(
  parameter [15:0] OSC_SETTLE_EDGES = `DCSU_OSC_SETTLE
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        osc_input_in,
  output reg         osc_output_out,
  input  wire        serial_clock_in,
  input  wire        serial_in_line_a_in,
  input  wire        serial_in_line_b_in,
  output wire        serial_out_line_a_out,
  output wire        serial_out_line_b_out,
  input  wire [9:0]  clock_select_setting_a_in,
  input  wire [9:0]  clock_select_setting_b_in,
  input  wire [1:0]  tx_enable_in,
  input  wire [1:0]  local_loopback_in,
  input  wire [3:0]  char_length_in,
  input  wire [3:0]  parity_mode_in,
  input  wire [1:0]  parity_force_in,
  input  wire [11:0] stop_length_in,
  input  wire [15:0] tx_data_in,
  input  wire [1:0]  tx_write_in,
  output wire [1:0]  tx_ready_out,
  output wire [1:0]  transmitter_empty_flag_out,
  output wire [15:0] rx_data_out,
  output wire [5:0]  rx_status_out,
  output wire [1:0]  rx_ready_out,
  input  wire [1:0]  rx_read_in,
  output wire [1:0]  overrun_out,
  input  wire [1:0]  status_clear_in,
  output wire [8:0]  interrupt_status_view_out,
  input  wire [8:0]  interrupt_enable_mask_in,
  output wire        irq_out,
  output wire        oscillator_unstable_flag_out
);
  wire        osc_lvl;
  wire        osc_rise;
  wire        sclk_rise;
  wire        sclk_fall;
  wire [1:0]  rx_lvl;
  wire [1:0]  tx_pin;
  wire [19:0] cs_all = {clock_select_setting_b_in, clock_select_setting_a_in};
  wire [7:0]  view_w;
  reg  [15:0] osc_cnt_q;
  reg         osc_unstable_q;

  dcsu_sync u_osc_sync (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .level_in  (osc_input_in),
    .level_out (osc_lvl),
    .rise_out  (osc_rise),
    .fall_out  ()
  );
  dcsu_sync u_sclk_sync (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .level_in  (serial_clock_in),
    .level_out (),
    .rise_out  (sclk_rise),
    .fall_out  (sclk_fall)
  );
  dcsu_sync u_rxa_sync (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .level_in  (serial_in_line_a_in),
    .level_out (rx_lvl[0]),
    .rise_out  (),
    .fall_out  ()
  );
  dcsu_sync u_rxb_sync (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .level_in  (serial_in_line_b_in),
    .level_out (rx_lvl[1]),
    .rise_out  (),
    .fall_out  ()
  );

  // oscillator counts as unstable until enough edges have been seen
  always @(posedge clock_in) begin
    if (rst_in) begin
      osc_cnt_q      <= 16'h0000;
      osc_unstable_q <= 1'b1;
      osc_output_out <= 1'b0;
    end else begin
      osc_output_out <= ~osc_lvl;
      if (osc_rise && osc_unstable_q) begin
        osc_cnt_q <= osc_cnt_q + 16'h0001;
        if (osc_cnt_q >= OSC_SETTLE_EDGES - 16'h0001) begin
          osc_unstable_q <= 1'b0;
        end
      end
    end
  end
  assign oscillator_unstable_flag_out = osc_unstable_q;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      wire [9:0] cs      = cs_all[g*10 +: 10];
      wire [4:0] tsel    = cs[4:0];
      wire [4:0] rsel    = cs[9:5];
      wire [1:0] len     = char_length_in[g*2 +: 2];
      wire [1:0] pm      = parity_mode_in[g*2 +: 2];
      wire       pforce  = parity_force_in[g];
      wire       loop    = local_loopback_in[g];
      wire [5:0] sl_raw  = stop_length_in[g*6 +: 6];
      wire [5:0] sl      = (sl_raw < `DCSU_STOP_MIN) ? `DCSU_STOP_MIN :
                           (sl_raw > `DCSU_STOP_MAX) ? `DCSU_STOP_MAX : sl_raw;
      wire [2:0] nb_m1   = {1'b0, len} + 3'h4;
      wire [7:0] dmask   = 8'hff >> (2'h3 - len);
      wire       par_en  = (pm != `DCSU_PAR_NONE);
      wire       gen_tt;
      wire       gen_rt;

      dcsu_baud_gen u_tx_gen (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .osc_tick_in (osc_rise),
        .rate_sel_in (tsel),
        .tick_out    (gen_tt)
      );
      dcsu_baud_gen u_rx_gen (
        .clock_in    (clock_in),
        .rst_in      (rst_in),
        .osc_tick_in (osc_rise),
        .rate_sel_in (rsel),
        .tick_out    (gen_rt)
      );

      // transmitter
      reg  [2:0] tst_q;
      reg  [3:0] tcnt_q;
      reg  [2:0] tbit_q;
      reg  [7:0] tsh_q;
      reg  [7:0] thold_q;
      reg        thold_full_q;
      reg        tline_q;
      reg        tout_q;
      reg        tempty_q;
      reg  [5:0] tstop_q;
      wire       t_ext   = (tsel == `DCSU_CS_EXT16) || (tsel == `DCSU_CS_EXT1);
      wire       t_x1    = (tsel == `DCSU_CS_EXT1);
      wire       ttick   = t_ext ? sclk_fall : gen_tt;
      wire       tbit_end = ttick && (t_x1 || tcnt_q == 4'hf);
      wire [7:0] tdat    = tsh_q & dmask;
      wire       tpar    = (pm == `DCSU_PAR_FORCE) ? pforce :
                           (pm == `DCSU_PAR_ODD) ? ~^tdat : ^tdat;
      wire [5:0] tinc    = t_x1 ? `DCSU_SIXTEENTHS : 6'h01;
      wire       tstop_done = (tst_q == `DCSU_ST_STOP) && ttick && (tstop_q + tinc >= sl);
      wire       tstart_ok  = tx_enable_in[g] && thold_full_q;
      wire       twr     = tx_write_in[g] && !thold_full_q;

      always @(posedge clock_in) begin
        if (rst_in) begin
          tst_q        <= `DCSU_ST_IDLE;
          tcnt_q       <= 4'h0;
          tbit_q       <= 3'h0;
          tsh_q        <= 8'h00;
          thold_q      <= 8'h00;
          thold_full_q <= 1'b0;
          tline_q      <= 1'b1;
          tout_q       <= 1'b1;
          tempty_q     <= 1'b1;
          tstop_q      <= 6'h00;
        end else begin
          tout_q <= loop ? 1'b1 : tline_q;
          if (twr) begin
            thold_q      <= tx_data_in[g*8 +: 8];
            thold_full_q <= 1'b1;
            tempty_q     <= 1'b0;
          end
          if (ttick && tst_q != `DCSU_ST_IDLE) begin
            tcnt_q <= tcnt_q + 4'h1;
          end
          case (tst_q)
            `DCSU_ST_IDLE: begin
              if (ttick && tstart_ok) begin
                tsh_q        <= thold_q;
                thold_full_q <= 1'b0;
                tline_q      <= 1'b0;
                tcnt_q       <= 4'h0;
                tst_q        <= `DCSU_ST_START;
              end
            end
            `DCSU_ST_START: begin
              if (tbit_end) begin
                tline_q <= tsh_q[0];
                tbit_q  <= 3'h0;
                tst_q   <= `DCSU_ST_DATA;
              end
            end
            `DCSU_ST_DATA: begin
              if (tbit_end) begin
                if (tbit_q == nb_m1) begin
                  tstop_q <= 6'h00;
                  if (par_en) begin
                    tline_q <= tpar;
                    tst_q   <= `DCSU_ST_PAR;
                  end else begin
                    tline_q <= 1'b1;
                    tst_q   <= `DCSU_ST_STOP;
                  end
                end else begin
                  tbit_q  <= tbit_q + 3'h1;
                  tline_q <= tsh_q[tbit_q + 3'h1];
                end
              end
            end
            `DCSU_ST_PAR: begin
              if (tbit_end) begin
                tline_q <= 1'b1;
                tst_q   <= `DCSU_ST_STOP;
              end
            end
            `DCSU_ST_STOP: begin
              if (ttick) begin
                tstop_q <= tstop_q + tinc;
              end
              if (tstop_done) begin
                tcnt_q <= 4'h0;
                if (tstart_ok) begin
                  tsh_q        <= thold_q;
                  thold_full_q <= 1'b0;
                  tline_q      <= 1'b0;
                  tst_q        <= `DCSU_ST_START;
                end else begin
                  tst_q <= `DCSU_ST_IDLE;
                  if (!twr) begin
                    tempty_q <= 1'b1;
                  end
                end
              end
            end
            default: tst_q <= `DCSU_ST_IDLE;
          endcase
        end
      end
      assign tx_pin[g]                     = tout_q;
      assign tx_ready_out[g]               = !thold_full_q;
      assign transmitter_empty_flag_out[g] = tempty_q;

      // receiver
      reg  [2:0]  rst_q;
      reg  [3:0]  rcnt_q;
      reg  [2:0]  rbit_q;
      reg  [7:0]  rsh_q;
      reg         rpbit_q;
      reg         rperr_q;
      reg  [10:0] fifo_q [0:3];
      reg  [1:0]  wr_q;
      reg  [1:0]  rd_q;
      reg  [2:0]  fcnt_q;
      reg         ovr_q;
      reg         brkchg_q;
      wire        rl     = loop ? tline_q : rx_lvl[g];
      wire        r_ext  = (rsel == `DCSU_CS_EXT16) || (rsel == `DCSU_CS_EXT1);
      wire        r_x1   = (rsel == `DCSU_CS_EXT1);
      wire        rtick  = r_ext ? sclk_rise : gen_rt;
      wire        rsamp  = rtick && (r_x1 || rcnt_q == 4'hf);
      wire [7:0]  rdat   = rsh_q & dmask;
      wire        rexp   = (pm == `DCSU_PAR_FORCE) ? pforce :
                           (pm == `DCSU_PAR_ODD) ? ~^rdat : ^rdat;
      wire        push   = (rst_q == `DCSU_ST_STOP) && rsamp;
      wire        rbrk   = (rdat == 8'h00) && !rl && !(par_en && rpbit_q);
      wire        full   = (fcnt_q == `DCSU_RX_DEPTH);
      wire        wr_ok  = push && !full;
      wire        pop    = rx_read_in[g] && (fcnt_q != 3'h0);
      wire        brk_end = (rst_q == `DCSU_ST_BRK) && rtick && rl;
      wire        clr    = status_clear_in[g];

      always @(posedge clock_in) begin
        if (rst_in) begin
          rst_q    <= `DCSU_ST_IDLE;
          rcnt_q   <= 4'h0;
          rbit_q   <= 3'h0;
          rsh_q    <= 8'h00;
          rpbit_q  <= 1'b0;
          rperr_q  <= 1'b0;
          wr_q     <= 2'h0;
          rd_q     <= 2'h0;
          fcnt_q   <= 3'h0;
          ovr_q    <= 1'b0;
          brkchg_q <= 1'b0;
        end else begin
          if (rtick && rst_q != `DCSU_ST_IDLE) begin
            rcnt_q <= rcnt_q + 4'h1;
          end
          case (rst_q)
            `DCSU_ST_IDLE: begin
              if (rtick && !rl) begin
                rcnt_q  <= 4'h0;
                rbit_q  <= 3'h0;
                rsh_q   <= 8'h00;
                rperr_q <= 1'b0;
                rpbit_q <= 1'b0;
                rst_q   <= r_x1 ? `DCSU_ST_DATA : `DCSU_ST_START;
              end
            end
            `DCSU_ST_START: begin
              // mid-bit recheck rejects glitches as false starts
              if (rtick && rcnt_q == 4'h7) begin
                rcnt_q <= 4'h0;
                rst_q  <= rl ? `DCSU_ST_IDLE : `DCSU_ST_DATA;
              end
            end
            `DCSU_ST_DATA: begin
              if (rsamp) begin
                rsh_q[rbit_q] <= rl;
                rbit_q        <= rbit_q + 3'h1;
                if (rbit_q == nb_m1) begin
                  rst_q <= par_en ? `DCSU_ST_PAR : `DCSU_ST_STOP;
                end
              end
            end
            `DCSU_ST_PAR: begin
              if (rsamp) begin
                rpbit_q <= rl;
                rperr_q <= (rl != rexp);
                rst_q   <= `DCSU_ST_STOP;
              end
            end
            `DCSU_ST_STOP: begin
              if (rsamp) begin
                rst_q <= rbrk ? `DCSU_ST_BRK : `DCSU_ST_IDLE;
              end
            end
            `DCSU_ST_BRK: begin
              if (brk_end) begin
                rst_q <= `DCSU_ST_IDLE;
              end
            end
            default: rst_q <= `DCSU_ST_IDLE;
          endcase
          if (wr_ok) begin
            fifo_q[wr_q] <= {rbrk, !rl, rperr_q, rdat};
            wr_q         <= wr_q + 2'h1;
          end
          if (pop) begin
            rd_q <= rd_q + 2'h1;
          end
          fcnt_q <= fcnt_q + {2'h0, wr_ok} - {2'h0, pop};
          // a new event in the clearing cycle still wins
          ovr_q    <= (push && full) | (ovr_q & ~clr);
          brkchg_q <= (push && rbrk) | brk_end | (brkchg_q & ~clr);
        end
      end
      assign rx_data_out[g*8 +: 8]   = fifo_q[rd_q][7:0];
      assign rx_status_out[g*3 +: 3] = fifo_q[rd_q][10:8];
      assign rx_ready_out[g]         = (fcnt_q != 3'h0);
      assign overrun_out[g]          = ovr_q;
      assign view_w[g*4 +: 4]        = {tempty_q, brkchg_q, rx_ready_out[g], !thold_full_q};
    end
  endgenerate

  assign serial_out_line_a_out     = tx_pin[0];
  assign serial_out_line_b_out     = tx_pin[1];
  assign interrupt_status_view_out = {osc_unstable_q, view_w};
  assign irq_out = |(interrupt_status_view_out & interrupt_enable_mask_in);
endmodule // dcsu_top
`default_nettype wire

// file: shared/dcsu_map.vh
// Purpose: constants for the dual channel serial uart
// Assumes: included by bare name from every file that uses its constants
// Notes:   clock select codes below the external ones pick a fixed rate
`ifndef DCSU_MAP_VH
`define DCSU_MAP_VH
`define DCSU_RATE_COUNT   5'h13
`define DCSU_CS_EXT16     5'h13
`define DCSU_CS_EXT1      5'h14
`define DCSU_PAR_EVEN     2'h0
`define DCSU_PAR_ODD      2'h1
`define DCSU_PAR_NONE     2'h2
`define DCSU_PAR_FORCE    2'h3
`define DCSU_STOP_MIN     6'h09
`define DCSU_STOP_MAX     6'h20
`define DCSU_SIXTEENTHS   6'h10
`define DCSU_OSC_SETTLE   16'h0400
`define DCSU_RX_DEPTH     3'h4
`define DCSU_ST_IDLE      3'h0
`define DCSU_ST_START     3'h1
`define DCSU_ST_DATA      3'h2
`define DCSU_ST_PAR       3'h3
`define DCSU_ST_STOP      3'h4
`define DCSU_ST_BRK       3'h5
`endif

// file: rtl/dcsu_sync.v
// Purpose: two flop synchroniser with edge pulses
// Assumes: level_in is asynchronous to clock_in
// Notes:   edges are taken from the second flop onward only
`timescale 1ns/100ps
`default_nettype none
module dcsu_sync (
  input  wire clock_in,
  input  wire rst_in,
  input  wire level_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta_q;
  reg sync_q;
  reg prev_q;
  always @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= level_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule // dcsu_sync
`default_nettype wire

// file: rtl/dcsu_baud_gen.v
// Purpose: sixteen times rate tick from the oscillator
// Assumes: osc_tick_in pulses once per oscillator period
// Notes:   divisors assume the nominal oscillator frequency
`timescale 1ns/100ps
`default_nettype none
`include "dcsu_map.vh"
module dcsu_baud_gen (
  input  wire       clock_in,
  input  wire       rst_in,
  input  wire       osc_tick_in,
  input  wire [4:0] rate_sel_in,
  output reg        tick_out
);
  reg  [12:0] cnt_q;
  reg  [12:0] div_w;
  always @* begin
    case (rate_sel_in)
      5'h00:   div_w = 13'h1200;
      5'h01:   div_w = 13'h0c00;
      5'h02:   div_w = 13'h082f;
      5'h03:   div_w = 13'h06b1;
      5'h04:   div_w = 13'h0600;
      5'h05:   div_w = 13'h0480;
      5'h06:   div_w = 13'h0300;
      5'h07:   div_w = 13'h0180;
      5'h08:   div_w = 13'h00db;
      5'h09:   div_w = 13'h00c0;
      5'h0a:   div_w = 13'h0080;
      5'h0b:   div_w = 13'h0073;
      5'h0c:   div_w = 13'h0060;
      5'h0d:   div_w = 13'h0030;
      5'h0e:   div_w = 13'h0020;
      5'h0f:   div_w = 13'h0018;
      5'h10:   div_w = 13'h000c;
      5'h11:   div_w = 13'h0006;
      5'h12:   div_w = 13'h0003;
      default: div_w = 13'h0003;
    endcase
  end
  // >= keeps a rate change from stranding the counter above the divisor
  always @(posedge clock_in) begin
    if (rst_in) begin
      cnt_q    <= 13'h0000;
      tick_out <= 1'b0;
    end else if (osc_tick_in) begin
      if (cnt_q >= div_w - 13'h0001) begin
        cnt_q    <= 13'h0000;
        tick_out <= 1'b1;
      end else begin
        cnt_q    <= cnt_q + 13'h0001;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule // dcsu_baud_gen
`default_nettype wire

// file: verif/dcsu_top_sva.sv
// Purpose: port level checks for the dual channel serial uart
// Assumes: channel a is the channel exercised on the external clock
// Notes:   sees only the top module ports
`timescale 1ns/100ps
`default_nettype none
`include "dcsu_map.vh"
module dcsu_top_sva #(
  parameter [15:0] OSC_SETTLE_EDGES = 16'h0400
) (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        serial_clock_in,
  input wire logic        serial_out_line_a_out,
  input wire logic [9:0]  clock_select_setting_a_in,
  input wire logic [1:0]  local_loopback_in,
  input wire logic [1:0]  tx_write_in,
  input wire logic [1:0]  tx_ready_out,
  input wire logic [1:0]  transmitter_empty_flag_out,
  input wire logic [15:0] rx_data_out,
  input wire logic [5:0]  rx_status_out,
  input wire logic [1:0]  rx_ready_out,
  input wire logic [1:0]  rx_read_in,
  input wire logic [1:0]  overrun_out,
  input wire logic [1:0]  status_clear_in,
  input wire logic [8:0]  interrupt_status_view_out,
  input wire logic [8:0]  interrupt_enable_mask_in,
  input wire logic        irq_out,
  input wire logic        oscillator_unstable_flag_out
);
  logic       sclk_q;
  logic [3:0] since_fall_q;
  // raw pin sampled; the design adds its own synchroniser delay on top
  always @(posedge clock_in) begin
    sclk_q <= serial_clock_in;
    if (sclk_q && !serial_clock_in)
      since_fall_q <= 4'h0;
    else if (since_fall_q != 4'hf)
      since_fall_q <= since_fall_q + 4'h1;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence s_tx_take;
    tx_write_in[0] && tx_ready_out[0];
  endsequence
  sequence s_tx_busy;
    !tx_ready_out[0] && !transmitter_empty_flag_out[0];
  endsequence
  chk_write_takes: assert property (s_tx_take |=> s_tx_busy)
    else $error("accepted write left holding stage free");
  chk_empty_mark: assert property (transmitter_empty_flag_out[0] |-> serial_out_line_a_out)
    else $error("line not at mark while transmitter empty");
  chk_loop_mark: assert property (local_loopback_in[0] && $past(local_loopback_in[0])
    |-> serial_out_line_a_out)
    else $error("line not at mark in loopback");
  chk_irq_level: assert property (irq_out == |(interrupt_status_view_out & interrupt_enable_mask_in))
    else $error("interrupt request disagrees with masked view");
  chk_view_bits: assert property (interrupt_status_view_out[3:0] == {transmitter_empty_flag_out[0],
    interrupt_status_view_out[2], rx_ready_out[0], tx_ready_out[0]})
    else $error("status view disagrees with channel flags");
  chk_view_osc: assert property (interrupt_status_view_out[8] == oscillator_unstable_flag_out)
    else $error("status view misses oscillator flag");
  chk_rx_hold: assert property (rx_ready_out[0] && !rx_read_in[0] |=> rx_ready_out[0]
    && $stable(rx_data_out[7:0]) && $stable(rx_status_out[2:0]))
    else $error("receive head changed without a read");
  chk_overrun_keep: assert property (overrun_out[0] && !status_clear_in[0] |=> overrun_out[0])
    else $error("overrun dropped without clear");
  chk_tx_falls: assert property ($changed(serial_out_line_a_out)
    && clock_select_setting_a_in[4:0] == `DCSU_CS_EXT1 |-> since_fall_q <= 4'h8)
    else $error("line changed away from a link clock fall");
endmodule // dcsu_top_sva
bind dcsu_top dcsu_top_sva #(.OSC_SETTLE_EDGES(OSC_SETTLE_EDGES)) chk (.clock_in, .rst_in,
  .serial_clock_in, .serial_out_line_a_out, .clock_select_setting_a_in, .local_loopback_in,
  .tx_write_in, .tx_ready_out, .transmitter_empty_flag_out, .rx_data_out, .rx_status_out,
  .rx_ready_out, .rx_read_in, .overrun_out, .status_clear_in, .interrupt_status_view_out,
  .interrupt_enable_mask_in, .irq_out, .oscillator_unstable_flag_out);
`default_nettype wire

// file: verif/dcsu_remote.sv
// Purpose: remote serial device on the channel a link
// Assumes: device runs channel a from the external x1 clock
// Notes:   link clock period is sixteen system clocks
`timescale 1ns/100ps
`default_nettype none
module dcsu_remote (
  input  wire logic clock_in,
  input  wire logic run_in,
  input  wire logic line_in,
  output logic      sclk_out,
  output logic      line_out
);
  logic q[$];
  initial begin
    sclk_out = 1'b0;
    line_out = 1'b1;
  end
  // slow enough that the device synchronisers see every edge
  always begin
    repeat (8) @(negedge clock_in);
    if (run_in)
      sclk_out = ~sclk_out;
  end
  always @(posedge sclk_out) q.push_back(line_in);
  // line returns to mark after the last bit, as an idle line does
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sclk_out);
      line_out = f[i];
    end
    @(negedge sclk_out);
    line_out = 1'b1;
  endtask
endmodule // dcsu_remote
`default_nettype wire

// file: verif/dcsu_top_tb.sv
// Purpose: self-checking bench for the dual channel serial uart
// Assumes: channel a on the external x1 clock, channel b on a fixed rate
// Notes:   inputs change on the falling clock edge
`timescale 1ns/100ps
`default_nettype none
`include "dcsu_map.vh"
module dcsu_top_tb;
  logic        clk = 1'b0, rst = 1'b1, osc = 1'b0, run = 1'b1;
  logic        sclk, rxa, txa, txb, irq, oscf;
  logic [9:0]  csa = 10'h000, csb = 10'h000;
  logic [1:0]  ten = 2'h3, lbk = 2'h0, wr = 2'h0, rd = 2'h0, clr = 2'h0;
  logic [1:0]  trdy, temp, rrdy, ovr;
  logic [3:0]  clen = 4'hf, pmode = 4'ha;
  logic [11:0] stop = 12'h410;
  logic [15:0] txd = 16'h0000, rxdat;
  logic [5:0]  rxst;
  logic [8:0]  view, mask = 9'h000;
  logic        eq[$];
  int          n_fail = 0, n_compared = 0, k;
  always #50 clk = ~clk;
  always #135.6 osc = ~osc;
  dcsu_top #(.OSC_SETTLE_EDGES(16'h0004)) dut (.clock_in(clk), .rst_in(rst),
    .osc_input_in(osc), .osc_output_out(), .serial_clock_in(sclk), .serial_in_line_a_in(rxa),
    .serial_in_line_b_in(1'b1), .serial_out_line_a_out(txa), .serial_out_line_b_out(txb),
    .clock_select_setting_a_in(csa), .clock_select_setting_b_in(csb), .tx_enable_in(ten),
    .local_loopback_in(lbk), .char_length_in(clen), .parity_mode_in(pmode),
    .parity_force_in(2'h3), .stop_length_in(stop), .tx_data_in(txd), .tx_write_in(wr),
    .tx_ready_out(trdy), .transmitter_empty_flag_out(temp), .rx_data_out(rxdat),
    .rx_status_out(rxst), .rx_ready_out(rrdy), .rx_read_in(rd), .overrun_out(ovr),
    .status_clear_in(clr), .interrupt_status_view_out(view), .interrupt_enable_mask_in(mask),
    .irq_out(irq), .oscillator_unstable_flag_out(oscf));
  dcsu_remote remote (.clock_in(clk), .run_in(run), .line_in(txa), .sclk_out(sclk),
    .line_out(rxa));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic expire(input string what);
    check(what, 16'h0000, 16'h0001);
    wrap_up();
  endtask
  task automatic frame(input logic [7:0] d, input int len, input int par, input int nstop);
    logic [7:0] m;
    m = 8'hff >> (3 - len);
    eq.push_back(1'b0);
    for (int i = 0; i < len + 5; i++) eq.push_back(d[i]);
    if (par != `DCSU_PAR_NONE)
      eq.push_back(par == `DCSU_PAR_FORCE ? 1'b1 : ^(d & m) ^ (par == `DCSU_PAR_ODD));
    repeat (nstop) eq.push_back(1'b1);
  endtask
  task automatic cfg(input int len, input int par, input int nstop);
    clen[1:0] = len[1:0];
    pmode[1:0] = par[1:0];
    stop[5:0] = nstop == 2 ? `DCSU_STOP_MAX : `DCSU_SIXTEENTHS;
  endtask
  task automatic put(input logic [7:0] d);
    for (k = 0; k < 2000 && trdy[0] !== 1'b1; k++) @(negedge clk);
    if (trdy[0] !== 1'b1) expire("tx_ready");
    txd[7:0] = d;
    wr[0] = 1'b1;
    @(negedge clk);
    wr[0] = 1'b0;
    @(negedge clk);
  endtask
  task automatic pop(input logic [7:0] d, input logic [2:0] st);
    for (k = 0; k < 4000 && rrdy[0] !== 1'b1; k++) @(negedge clk);
    if (rrdy[0] !== 1'b1) expire("rx_ready");
    check("rx_data", rxdat[7:0], d);
    check("rx_status", rxst[2:0], st);
    rd[0] = 1'b1;
    @(negedge clk);
    rd[0] = 1'b0;
    @(negedge clk);
  endtask
  task automatic send(input logic [7:0] d, input int len, input int par, input int flip);
    logic [11:0] f;
    eq.delete();
    frame(d, len, par, 1);
    foreach (eq[i]) f[i] = eq[i];
    if (flip >= 0) f[flip] = ~f[flip];
    remote.send(f, eq.size());
  endtask
  task automatic clear_st;
    clr[0] = 1'b1;
    @(negedge clk);
    clr[0] = 1'b0;
    @(negedge clk);
  endtask
  task automatic tx_cmp;
    for (k = 0; k < 4000 && temp[0] !== 1'b1; k++) @(negedge clk);
    if (temp[0] !== 1'b1) expire("tx_empty");
    while (remote.q.size() > 0 && remote.q[0] !== 1'b0) void'(remote.q.pop_front());
    foreach (eq[i]) check("tx_bit", remote.q[i], eq[i]);
    for (int i = eq.size(); i < remote.q.size(); i++) check("tx_idle", remote.q[i], 1'b1);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (k = 0; k < 4000 && oscf !== 1'b0; k++) @(negedge clk);
    if (oscf !== 1'b0) expire("osc_ready");
    check("view_osc", view[8], 1'b0);
    csa = {`DCSU_CS_EXT1, `DCSU_CS_EXT1};
    csb = {5'h00, 5'h12};
    mask = 9'h001;
    @(negedge clk);
    check("irq", irq, 1'b1);
    mask = 9'h100;
    @(negedge clk);
    check("irq_masked", irq, 1'b0);
    for (int len = 0; len < 4; len++)
      for (int par = 0; par < 4; par++) begin
        cfg(len, par, 1 + len % 2);
        remote.q.delete();
        eq.delete();
        frame(8'h5a + len + par, len, par, 1 + len % 2);
        frame(8'hc3 ^ len, len, par, 1 + len % 2);
        put(8'h5a + len + par);
        put(8'hc3 ^ len);
        // holding stage is full here, so this write must be dropped
        wr[0] = 1'b1;
        @(negedge clk);
        wr[0] = 1'b0;
        tx_cmp();
        send(8'h96 ^ par, len, par, -1);
        pop((8'h96 ^ par) & (8'hff >> (3 - len)), 3'h0);
      end
    cfg(3, `DCSU_PAR_EVEN, 1);
    send(8'h3c, 3, `DCSU_PAR_EVEN, 9);
    pop(8'h3c, 3'h1);
    send(8'h3c, 3, `DCSU_PAR_EVEN, 10);
    pop(8'h3c, 3'h2);
    send(8'h00, 3, `DCSU_PAR_EVEN, 10);
    pop(8'h00, 3'h6);
    repeat (2) @(posedge sclk);
    @(negedge clk);
    check("break_change", view[2], 1'b1);
    clear_st();
    check("break_clear", view[2], 1'b0);
    repeat (5) send(8'h11, 3, `DCSU_PAR_EVEN, -1);
    check("overrun", ovr[0], 1'b1);
    repeat (4) pop(8'h11, 3'h0);
    check("rx_drained", rrdy[0], 1'b0);
    clear_st();
    check("overrun_clear", ovr[0], 1'b0);
    lbk[0] = 1'b1;
    @(negedge clk);
    put(8'h42);
    pop(8'h42, 3'h0);
    check("loop_mark", txa, 1'b1);
    // sixteen-times use of the link clock, still looped back
    csa = {`DCSU_CS_EXT16, `DCSU_CS_EXT16};
    put(8'h24);
    pop(8'h24, 3'h0);
    run = 1'b0;
    txd[15:8] = 8'hff;
    wr[1] = 1'b1;
    @(negedge clk);
    wr[1] = 1'b0;
    for (k = 0; k < 4000 && txb !== 1'b0; k++) @(negedge clk);
    for (k = 0; k < 400 && txb === 1'b0; k++) @(negedge clk);
    // one start bit at the fastest fixed rate lasts about 130 system clocks
    check("bit_time", 16'(k >= 128 && k <= 133), 16'h0001);
    wrap_up();
  end
endmodule // dcsu_top_tb
`default_nettype wire
